// ===== rtl/tnc_timer.sv
// Top of the 8-bit timer/counter: APB registers, counter, compare unit,
// compare output pin and interrupt.
// Assumes an APB master on sys_clk and a CPU that pulses ovf_irq_ack
// when it enters the overflow interrupt handler.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps

module tnc_timer (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ovf_irq_ack,
   output logic             irq,
   output logic             compare_output_pin,
   output logic             compare_output_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // State and internal signals

   tnc_pkg::tnc_st_t s;
   tnc_pkg::tnc_st_t next_s;

   logic       tick;
   logic       overflow_flag;
   logic       compare_flag;
   logic       ovf_set;
   logic       ovf_clr;
   logic       cmp_set;
   logic       cmp_clr;

   logic       wr_en;
   logic       setup;
   logic       clear_on_match_mode;
   logic       match;
   logic       toggle_mode;
   logic [1:0] status;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler

   // Shares one divider chain over all factors
   tnc_prescale #(
      .DIV_W (10)
   ) u_prescale (
      .sys_clk (sys_clk),
      .rst     (rst),
      .sel     (s.ctrl.cs),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags

   tnc_flag u_ovf_flag (
      .sys_clk (sys_clk),
      .rst     (rst),
      .set     (ovf_set),
      .clr     (ovf_clr),
      .q       (overflow_flag)
   );

   tnc_flag u_cmp_flag (
      .sys_clk (sys_clk),
      .rst     (rst),
      .set     (cmp_set),
      .clr     (cmp_clr),
      .q       (compare_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus phase decode

   // Write lands at the access edge that sees pready high
   assign setup = psel && !penable;
   assign wr_en = psel && penable && s.pready && pwrite;

   ////////////////////////////////////////////////////////////////////////////
   // Mode and compare decode

   // Modes 1 and 3 count like normal mode here
   assign clear_on_match_mode = (s.ctrl.wgm == tnc_pkg::WGM_CLR_MATCH);

   // No shadow copy: a new compare value acts at once
   assign match = (s.count == s.compare);

   assign toggle_mode = (s.ctrl.com == tnc_pkg::COM_TOGGLE);

   ////////////////////////////////////////////////////////////////////////////
   // Flag events

   // Overflow on the tick where 8'hff rolls to 8'h00, in both modes
   assign ovf_set = tick && (s.count == tnc_pkg::COUNT_MAX);

   // Compare flag on every match tick, in any mode
   assign cmp_set = tick && match;

   // Write-one clears, plus the clear when the handler is entered
   assign ovf_clr = (wr_en && (paddr == tnc_pkg::ADDR_STATUS)
                     && pwdata[tnc_pkg::OVF_BIT]) || ovf_irq_ack;

   assign cmp_clr = wr_en && (paddr == tnc_pkg::ADDR_STATUS)
                    && pwdata[tnc_pkg::CMP_BIT];

   always_comb begin
      status                   = 2'h0;
      status[tnc_pkg::OVF_BIT] = overflow_flag;
      status[tnc_pkg::CMP_BIT] = compare_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_s = s;

      // Counter; a software write beats the tick in the same cycle
      if (wr_en && (paddr == tnc_pkg::ADDR_COUNT)) begin
         next_s.count = pwdata[7:0];
      end else if (tick) begin
         if (clear_on_match_mode && match) begin
            next_s.count = tnc_pkg::COUNT_ZERO;
         end else begin
            // Plain increment wraps 8'hff to 8'h00
            next_s.count = s.count + 8'h01;
         end
      end

      // Compare value, control and mask registers
      if (wr_en && (paddr == tnc_pkg::ADDR_COMPARE)) begin
         next_s.compare = pwdata[7:0];
      end
      if (wr_en && (paddr == tnc_pkg::ADDR_CTRL)) begin
         next_s.ctrl = tnc_pkg::tnc_ctrl_t'(pwdata[7:0]);
      end
      if (wr_en && (paddr == tnc_pkg::ADDR_MASK)) begin
         next_s.mask = pwdata[1:0];
      end

      // Output level flips on each match in clear-on-match toggle mode; zero compare and no
      // prescale gives a flip every clock
      if (tick && match && clear_on_match_mode && toggle_mode) begin
         next_s.level = !s.level;
      end

      // Pin driven only for an output direction and an active output mode
      next_s.oe  = s.ctrl.dir && (s.ctrl.com != tnc_pkg::COM_OFF);
      next_s.pin = s.level;

      // Interrupt lags the flags by one clock to stay registered
      next_s.irq = |(status & s.mask);

      // APB answer: one wait-free access cycle after setup
      next_s.pready  = setup;
      next_s.pslverr = 1'b0;
      if (setup) begin
         next_s.prdata = 32'h0000_0000;
         case (paddr)
            tnc_pkg::ADDR_CTRL:    next_s.prdata[7:0] = s.ctrl;
            tnc_pkg::ADDR_COUNT:   next_s.prdata[7:0] = s.count;
            tnc_pkg::ADDR_COMPARE: next_s.prdata[7:0] = s.compare;
            tnc_pkg::ADDR_STATUS:  next_s.prdata[1:0] = status;
            tnc_pkg::ADDR_MASK:    next_s.prdata[1:0] = s.mask;
            default:               next_s.pslverr     = 1'b1;
         endcase
      end else if (!psel) begin
         next_s.prdata = 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s         <= '0;
         s.count   <= tnc_pkg::RST_BYTE;
         s.compare <= tnc_pkg::RST_BYTE;
         s.mask    <= tnc_pkg::RST_MASK;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register

   assign prdata             = s.prdata;
   assign pready             = s.pready;
   assign pslverr            = s.pslverr;
   assign irq                = s.irq;
   assign compare_output_pin = s.pin;
   assign compare_output_oe  = s.oe;

endmodule // tnc_timer

// ===== rtl/tnc_pkg.sv
// Package of the 8-bit timer/counter: offsets, fields, reset values, types.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
// Notes on behaviour
// - In normal mode the count runs up to 8'hff, wraps to 8'h00 and keeps counting.
// - In normal mode the overflow flag sets in the timer tick where the count becomes zero.
// - The counter only ever sets the overflow flag and never clears it.
// - Servicing the overflow interrupt clears the overflow flag automatically.
// - In normal mode software may write a new count at any time.
// - In normal mode the compare unit still flags count equal to compare value.
// - Clear-on-match mode is selected by waveform_gen_select equal to 2.
// - In clear-on-match mode the count goes to zero on the tick after it equals the compare value.
// - In clear-on-match mode the compare flag sets each time the count reaches the top.
// - The compare value is not double buffered, so a value below the count is missed until wrap.
// - With compare_output_select equal to 1 in clear-on-match mode the output toggles per match.
// - The compare output drives the pin only while the pin direction is output.
// - With compare value zero and no prescaling the output toggles every clock.
// - The timer tick comes from the clock through a prescale of 1, 8, 64, 256 or 1024.
// - In clear-on-match mode the overflow flag sets when the count passes from 8'hff to 8'h00.

package tnc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_COUNT   = 8'h04;
   localparam logic [7:0] ADDR_COMPARE = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0c;
   localparam logic [7:0] ADDR_MASK    = 8'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int WGM_LSB = 0;
   localparam int COM_LSB = 2;
   localparam int CS_LSB  = 4;
   localparam int DIR_BIT = 7;

   // Status and mask bit positions
   localparam int OVF_BIT = 0;
   localparam int CMP_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Field encodings
   localparam logic [1:0] WGM_NORMAL    = 2'h0;
   localparam logic [1:0] WGM_CLR_MATCH = 2'h2;
   localparam logic [1:0] COM_OFF       = 2'h0;
   localparam logic [1:0] COM_TOGGLE    = 2'h1;

   // Clock select codes and divider masks (factor minus one)
   localparam logic [2:0] CS_STOP  = 3'h0;
   localparam logic [2:0] CS_DIV1  = 3'h1;
   localparam logic [2:0] CS_DIV8  = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [9:0] MASK_DIV8    = 10'h007;
   localparam logic [9:0] MASK_DIV64   = 10'h03f;
   localparam logic [9:0] MASK_DIV256  = 10'h0ff;
   localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and limits
   localparam logic [7:0] COUNT_MAX  = 8'hff;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [1:0] RST_MASK   = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic       dir;
      logic [2:0] cs;
      logic [1:0] com;
      logic [1:0] wgm;
   } tnc_ctrl_t;

   typedef struct packed {
      logic [9:0] cnt;
   } tnc_pre_st_t;

   typedef struct packed {
      logic q;
   } tnc_flag_st_t;

   typedef struct packed {
      logic [7:0]  count;
      tnc_ctrl_t   ctrl;
      logic [7:0]  compare;
      logic [1:0]  mask;
      logic        level;
      logic        pin;
      logic        oe;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tnc_st_t;

endpackage

// ===== rtl/tnc_prescale.sv
// Prescaler that turns the system clock into a timer tick.
// Assumes the select code comes from the control register of the timer.
`timescale 1ns/10ps

module tnc_prescale #(
   parameter int DIV_W = 10
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [2:0]       sel,
   output logic                  tick
);

   tnc_pkg::tnc_pre_st_t s;
   tnc_pkg::tnc_pre_st_t next_s;
   logic [DIV_W-1:0]     msk;

   ////////////////////////////////////////////////////////////////////////////
   // Free-running divider; shared by all factors so a change needs no restart
   always_comb begin
      next_s     = s;
      next_s.cnt = s.cnt + 10'h001;
      msk        = '0;
      tick       = 1'b0;
      case (sel)
         tnc_pkg::CS_DIV1:    msk = '0;
         tnc_pkg::CS_DIV8:    msk = tnc_pkg::MASK_DIV8;
         tnc_pkg::CS_DIV64:   msk = tnc_pkg::MASK_DIV64;
         tnc_pkg::CS_DIV256:  msk = tnc_pkg::MASK_DIV256;
         tnc_pkg::CS_DIV1024: msk = tnc_pkg::MASK_DIV1024;
         default:             msk = '0;
      endcase
      // One tick per factor cycles, none while stopped
      tick = (sel != tnc_pkg::CS_STOP) && (sel <= tnc_pkg::CS_DIV1024)
             && ((s.cnt & msk) == msk);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule // tnc_prescale

// ===== rtl/tnc_flag.sv
// Sticky event flag with one clear input; the top feeds it a software clear, plus an automatic clear for overflow only.
// Assumes set and clear inputs are single-cycle pulses on sys_clk.
`timescale 1ns/10ps

module tnc_flag (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);

   tnc_pkg::tnc_flag_st_t s;
   tnc_pkg::tnc_flag_st_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   // Set wins over clear so an event in the clearing cycle is kept
   always_comb begin
      next_s = s;
      if (set) begin
         next_s.q = 1'b1;
      end else if (clr) begin
         next_s.q = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;

endmodule // tnc_flag

// ===== test/tnc_sva.sv
// Port checker of the 8-bit timer: bus timing, pin enable, interrupt gate.
// Bound to tnc_timer; keeps its own copies of CTRL and MASK from bus writes.
`timescale 1ns/10ps
module tnc_sva (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ovf_irq_ack,
   input wire logic        irq,
   input wire logic        compare_output_pin,
   input wire logic        compare_output_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic       wr_ok;
   logic       tog;
   logic [7:0] sh_ctrl;
   logic [1:0] sh_mask;
   ////////////////////////////////////////////////////////////////////////////
   // Shadows, since the registers are out of sight
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign tog   = sh_ctrl[1:0] == tnc_pkg::WGM_CLR_MATCH
                  && sh_ctrl[3:2] == tnc_pkg::COM_TOGGLE;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sh_ctrl <= 8'h00;
         sh_mask <= 2'h0;
      end else if (wr_ok && paddr == tnc_pkg::ADDR_CTRL) begin
         sh_ctrl <= pwdata[7:0];
      end else if (wr_ok && paddr == tnc_pkg::ADDR_MASK) begin
         sh_mask <= pwdata[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_unmapped: assert property (psel && !penable && paddr > tnc_pkg::ADDR_MASK
      |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !pready
      && !compare_output_pin && !compare_output_oe) else $error("output up after reset");
   a_oe_on: assert property (wr_ok && paddr == tnc_pkg::ADDR_CTRL && pwdata[7]
      && pwdata[3:2] != 2'h0 |-> ##2 compare_output_oe) else $error("pin not driven");
   a_oe_off: assert property (wr_ok && paddr == tnc_pkg::ADDR_CTRL && !pwdata[7]
      |-> ##2 !compare_output_oe) else $error("pin driven while input");
   a_pin_frozen: assert property (!tog |-> ##2 $stable(compare_output_pin))
      else $error("pin moved outside toggle mode");
   a_irq_masked: assert property (sh_mask == 2'h0 |=> !irq)
      else $error("irq while masked");
   a_rdata_idle: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
      else $error("read data outside transfer");
   c_refused: cover property (pslverr);
   c_toggle: cover property ($rose(compare_output_pin));
   c_ack: cover property (ovf_irq_ack && irq);
endmodule // tnc_sva
bind tnc_timer tnc_sva u_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ovf_irq_ack(ovf_irq_ack), .irq(irq),
   .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe));

// ===== test/timer8_normal_ctc_tb_top.sv
// Bench of the 8-bit timer: registers, modes, prescale, interrupts.
// Assumes tnc_timer and tnc_pkg; the port checker attaches by bind.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
   $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module timer8_normal_ctc_tb_top;
   logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        ovf_irq_ack = 1'b0, pready, pslverr, irq, pin, oe, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          n_errors = 0, samples_checked = 0, cyc = 0, t0, t1, t2;
   int          cs[6] = '{1, 1, 2, 3, 4, 5};
   int          dv[6] = '{1, 1, 8, 64, 256, 1024};
   int          cm[6] = '{3, 0, 1, 1, 1, 1};
   tnc_timer dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ovf_irq_ack(ovf_irq_ack), .irq(irq),
      .compare_output_pin(pin), .compare_output_oe(oe));
   // Clock and hang guard; cycle count doubles as a time stamp
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle; waits on pready since the latency is the slave's business
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Only the cycle ceiling ends a wait that never sees pready
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Edge stamp of the next change of irq or pin
   task automatic wait_chg(input logic on_irq, output int t);
      logic l;
      int   n;
      l = on_irq ? irq : pin;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((on_irq ? irq : pin) === l && n < 4000);
      `CHK("change seen", 1'b1, n < 4000)
      t = cyc;
   endtask
   task automatic pulse_ack();
      ovf_irq_ack <= 1'b1;
      @(posedge sys_clk);
      ovf_irq_ack <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         `CHK("reset value", 32'h0, rd)
      end
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped", 1'b1, err)
      wr(tnc_pkg::ADDR_COMPARE, 32'hffffffab);
      apb(1'b0, tnc_pkg::ADDR_COMPARE, 32'h0);
      `CHK("readback", 32'hab, rd)
      $display("test reset done");
   endtask
   // Toggle gap is prescale times (compare + 1); the first gaps are skipped
   task automatic t_match();
      for (int i = 0; i < 6; i++) begin
         wr(tnc_pkg::ADDR_COMPARE, 32'(cm[i]));
         wr(tnc_pkg::ADDR_CTRL, 32'h86 | 32'(cs[i] << 4));
         wait_chg(1'b0, t0);
         wait_chg(1'b0, t1);
         wait_chg(1'b0, t2);
         `CHK("gap", dv[i] * (cm[i] + 1), t2 - t1)
         `CHK("oe", 1'b1, oe)
      end
      // Output mode 2 drives the pin but holds its level
      wr(tnc_pkg::ADDR_CTRL, 32'h9a);
      repeat (2) @(posedge sys_clk);
      err = pin;
      repeat (20) @(posedge sys_clk);
      `CHK("pin held", err, pin)
      `CHK("oe mode 2", 1'b1, oe)
      wr(tnc_pkg::ADDR_CTRL, 32'h16);
      repeat (2) @(posedge sys_clk);
      `CHK("oe off", 1'b0, oe)
      wr(tnc_pkg::ADDR_COMPARE, 32'h40);
      wr(tnc_pkg::ADDR_STATUS, 32'h3);
      wait_chg(1'b0, t0);
      wait_chg(1'b0, t0);
      wr(tnc_pkg::ADDR_COMPARE, 32'h2);
      wait_chg(1'b0, t1);
      `CHK("missed match", 259, t1 - t0)
      apb(1'b0, tnc_pkg::ADDR_STATUS, 32'h0);
      `CHK("match flags", 32'h3, rd)
      $display("test clear on match done");
   endtask
   task automatic t_normal();
      wr(tnc_pkg::ADDR_MASK, 32'h1);
      wr(tnc_pkg::ADDR_CTRL, 32'h10);
      wr(tnc_pkg::ADDR_STATUS, 32'h3);
      repeat (2) @(posedge sys_clk);
      wait_chg(1'b1, t0);
      repeat (300) @(posedge sys_clk);
      `CHK("sticky", 1'b1, irq)
      pulse_ack();
      `CHK("acked", 1'b0, irq)
      wait_chg(1'b1, t1);
      `CHK("wrap", 512, t1 - t0)
      pulse_ack();
      wr(tnc_pkg::ADDR_COUNT, 32'hf0);
      t0 = cyc;
      wait_chg(1'b1, t1);
      `CHK("count load", 18, t1 - t0)
      $display("test normal done");
   endtask
   task automatic t_cmp();
      wr(tnc_pkg::ADDR_CTRL, 32'h0);
      wr(tnc_pkg::ADDR_MASK, 32'h2);
      wr(tnc_pkg::ADDR_STATUS, 32'h3);
      wr(tnc_pkg::ADDR_COUNT, 32'h0);
      wr(tnc_pkg::ADDR_COMPARE, 32'h20);
      wr(tnc_pkg::ADDR_CTRL, 32'h10);
      wait_chg(1'b1, t0);
      apb(1'b0, tnc_pkg::ADDR_STATUS, 32'h0);
      `CHK("status", 32'h2, rd)
      wr(tnc_pkg::ADDR_STATUS, 32'h2);
      repeat (2) @(posedge sys_clk);
      `CHK("cleared", 1'b0, irq)
      // Reserved clock select gives no ticks; a loaded count stays put
      wr(tnc_pkg::ADDR_CTRL, 32'h70);
      wr(tnc_pkg::ADDR_COUNT, 32'h55);
      repeat (20) @(posedge sys_clk);
      apb(1'b0, tnc_pkg::ADDR_COUNT, 32'h0);
      `CHK("no tick", 32'h55, rd)
      $display("test compare done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_match();
      t_normal();
      t_cmp();
      final_report();
   end
endmodule // timer8_normal_ctc_tb_top
